// ===== core/cac_counter_array_control.v
// counter array control register: run bit, 16-bit counter, overflow and module flags
// assumes a CPU special-function-register port on sys_clk; module events and
// watchdog enable come from logic on the same clock
//
// Overview of operation
// - Overflow flag, bit 7, sets when the 16-bit counter wraps from 0xFFFF to 0.
// - Enabled overflow flag setting requests the shared array interrupt.
// - Hardware never clears the overflow flag; software must clear it.
// - Bit 6 run bit: 0 stops the counter, 1 lets it count.
// - Module n event sets capture/compare flag at bit n, bits 0 to 5.
// - Enabled module flag setting requests the shared array interrupt.
// - Module flags stay set until software clears them.
// - Writing 1 to module five flag while watchdog active forces watchdog reset.
// - Watchdog on: run bit writes ignored, counter runs, bit reads software value.
`timescale 1ns/10ps
`include "cac_consts.vh"
module cac_counter_array_control #(
    parameter NUM_MODULES = `CAC_NUM_MODULES, // capture/compare modules
    parameter CNT_WIDTH = 16 // array counter width
) (
    input wire sys_clk, // system clock, 100 MHz
    input wire rstn, // asynchronous reset, active low
    input wire [7:0] sfrAddr, // register address
    input wire sfrWrEn, // write strobe, one cycle
    input wire [7:0] sfrWrData, // write data
    input wire sfrRdEn, // read strobe, one cycle
    output reg [7:0] sfrRdData_reg, // read data, valid cycle after strobe
    input wire counterTick, // counter clock enable pulse
    input wire [NUM_MODULES-1:0] moduleEvent, // match or capture pulses
    input wire overflowIntEn, // overflow interrupt enable
    input wire [NUM_MODULES-1:0] moduleIntEn, // per-module interrupt enables
    input wire watchdogEnable, // watchdog function active
    output reg [CNT_WIDTH-1:0] counter_reg, // array counter value
    output reg intRequest_reg, // interrupt request pulse
    output reg watchdogReset_reg // forced watchdog reset pulse
);
    reg runSoft_reg;
    reg [CNT_WIDTH-1:0] counter_next;
    wire ctrlWr;
    wire counting;
    wire wrap;
    wire ovfFlag;
    wire ovfSet;
    wire [NUM_MODULES-1:0] modFlag;
    wire [NUM_MODULES-1:0] modSet;
    wire [7:0] ctrlView;

    assign ctrlWr = sfrWrEn && (sfrAddr == `CAC_CTRL_ADDR);
    // watchdog forces the counter on regardless of the software run bit
    assign counting = (runSoft_reg | watchdogEnable) & counterTick;
    assign wrap = counting && (counter_reg == `CAC_CNT_MAX);

    // counter advance; wraps naturally to zero
    always @* begin
        counter_next = counter_reg;
        if (counting) counter_next = counter_reg + {{(CNT_WIDTH-1){1'b0}}, 1'b1};
    end

    // software run bit; writes are dropped while the watchdog owns the counter
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            runSoft_reg <= 1'b0;
            counter_reg <= `CAC_CNT_RESET;
        end else begin
            if (ctrlWr && !watchdogEnable) runSoft_reg <= sfrWrData[`CAC_RUN_BIT];
            counter_reg <= counter_next;
        end
    end

    // overflow flag: only the written zero clears it, never the interrupt
    cac_flag_cell u_ovf (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .setEvt(wrap),
        .wrEn(ctrlWr),
        .wrBit(sfrWrData[`CAC_OVF_BIT]),
        .flag_reg(ovfFlag),
        .setPulse_reg(ovfSet)
    );

    // one sticky flag per module at its own bit position
    genvar i;
    generate
        for (i = 0; i < NUM_MODULES; i = i + 1) begin : g_mod
            cac_flag_cell u_mod (
                .sys_clk(sys_clk),
                .rstn(rstn),
                .setEvt(moduleEvent[i]),
                .wrEn(ctrlWr),
                .wrBit(sfrWrData[i]),
                .flag_reg(modFlag[i]),
                .setPulse_reg(modSet[i])
            );
        end
    endgenerate

    // run bit reads the software value, so zero when only the watchdog runs it
    assign ctrlView = {ovfFlag, runSoft_reg, modFlag};

    // read port, interrupt request and forced watchdog reset
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sfrRdData_reg <= `CAC_CTRL_RESET;
            intRequest_reg <= 1'b0;
            watchdogReset_reg <= 1'b0;
        end else begin
            if (sfrRdEn && (sfrAddr == `CAC_CTRL_ADDR)) sfrRdData_reg <= ctrlView;
            else if (sfrRdEn) sfrRdData_reg <= 8'h00;
            intRequest_reg <= (ovfSet & overflowIntEn) | (|(modSet & moduleIntEn));
            watchdogReset_reg <= ctrlWr && watchdogEnable && sfrWrData[`CAC_WDFLAG_BIT];
        end
    end
endmodule // cac_counter_array_control

// ===== core/cac_consts.vh
// constants for the counter array control/status register block
// included by the control register module only; the flag cell uses none of them
`ifndef CAC_CONSTS_VH
`define CAC_CONSTS_VH
`define CAC_CTRL_ADDR 8'hd8
`define CAC_CTRL_RESET 8'h00
`define CAC_OVF_BIT 7
`define CAC_RUN_BIT 6
`define CAC_WDFLAG_BIT 5
`define CAC_NUM_MODULES 6
`define CAC_CNT_MAX 16'hffff
`define CAC_CNT_RESET 16'h0000
`endif

// ===== core/cac_flag_cell.v
// one sticky event flag: set by hardware, cleared by a written zero
// assumes wrEn and wrBit come from the same clock domain
`timescale 1ns/10ps
module cac_flag_cell (
    input wire sys_clk, // system clock
    input wire rstn, // asynchronous reset, active low
    input wire setEvt, // hardware set event, one-cycle pulse
    input wire wrEn, // register write strobe
    input wire wrBit, // written value of this bit
    output reg flag_reg, // flag state
    output reg setPulse_reg // pulse when the flag goes from 0 to 1
);
    reg flag_next;

    // set beats clear so a coincident event is never lost
    always @* begin
        flag_next = flag_reg;
        if (wrEn && !wrBit) flag_next = 1'b0;
        if (wrEn && wrBit) flag_next = 1'b1;
        if (setEvt) flag_next = 1'b1;
    end

    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            flag_reg <= 1'b0;
            setPulse_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
            setPulse_reg <= flag_next & ~flag_reg;
        end
    end
endmodule // cac_flag_cell

// ===== test/cac_ctrl_asserts.sv
// port checker for the counter array control register block
// assumes bind to every instance; one clock, async active-low reset
`timescale 1ns/10ps
module cac_ctrl_asserts #(parameter NUM_MODULES = 6, parameter CNT_WIDTH = 16) (
    input wire sys_clk, input wire rstn, input wire [7:0] sfrAddr, input wire sfrWrEn,
    input wire [7:0] sfrWrData, input wire sfrRdEn, input wire [7:0] sfrRdData_reg, input wire counterTick,
    input wire [NUM_MODULES-1:0] moduleEvent, input wire overflowIntEn, input wire [NUM_MODULES-1:0] moduleIntEn,
    input wire watchdogEnable, input wire [CNT_WIDTH-1:0] counter_reg, input wire intRequest_reg,
    input wire watchdogReset_reg);
default clocking @(posedge sys_clk); endclocking
default disable iff (!rstn);
// a software set of flag five under watchdog is the only cause of a forced reset
wire wdHit = sfrWrEn && sfrAddr == 8'hd8 && sfrWrData[5] && watchdogEnable;
cnt_hold_a: assert property (!counterTick |=> $stable(counter_reg)) else $error("counter moved");
cnt_step_a: assert property (!$stable(counter_reg) |-> counter_reg == $past(counter_reg) + 16'h0001)
    else $error("counter step");
wd_run_a: assert property (watchdogEnable && counterTick |=> !$stable(counter_reg)) else $error("wd stall");
wd_rst_a: assert property (wdHit |=> watchdogReset_reg) else $error("no wd reset");
wd_cause_a: assert property (watchdogReset_reg |-> $past(wdHit)) else $error("stray wd reset");
int_cause_a: assert property (intRequest_reg |-> $past(overflowIntEn || |moduleIntEn)) else $error("stray irq");
rd_hold_a: assert property (!sfrRdEn |=> $stable(sfrRdData_reg)) else $error("read data moved");
unmap_rd_a: assert property (sfrRdEn && sfrAddr != 8'hd8 |=> sfrRdData_reg == 8'h00) else $error("unmapped read");
endmodule // cac_ctrl_asserts
bind cac_counter_array_control cac_ctrl_asserts #(.NUM_MODULES(NUM_MODULES), .CNT_WIDTH(CNT_WIDTH)) i_chk (.*);

// ===== test/tb.sv
// self-checking bench for the counter array control register
// assumes the block alone; inputs change on falling edges
`timescale 1ns/10ps
module tb;
reg sys_clk = 0, rstn = 0, sfrWrEn = 0, sfrRdEn = 0, counterTick = 0, overflowIntEn = 1, watchdogEnable = 0;
reg rdSeen = 0;
reg [7:0] sfrAddr = 8'hd8, sfrWrData = 8'h00;
reg [5:0] moduleEvent = 6'h00, moduleIntEn = 6'h3f, m;
wire [7:0] sfrRdData_reg;
wire [15:0] counter_reg;
wire intRequest_reg, watchdogReset_reg;
int err_total = 0, n_checks = 0, nIrq = 0, nWd = 0;
logic [7:0] expQ[$];
cac_counter_array_control i_dut (.*);
initial forever #5 sys_clk = ~sys_clk;
task automatic cyc(input int n); repeat (n) @(negedge sys_clk); endtask
task automatic wr(input [7:0] d); sfrWrEn = 1; sfrWrData = d; cyc(1); sfrWrEn = 0; cyc(1); endtask
// reads note the expected byte; the monitor below compares it when the data lands
task automatic rd(input [7:0] a, input [7:0] e);
    sfrAddr = a; sfrRdEn = 1; expQ.push_back(e); cyc(1); sfrRdEn = 0; sfrAddr = 8'hd8; cyc(1);
endtask
task automatic chk(input [7:0] e, input [7:0] s);
    n_checks++;
    if (s !== e) begin err_total++; $display("BAD sfrRdData_reg exp %h got %h", e, s); end
endtask
always @(posedge sys_clk) rdSeen <= sfrRdEn;
always @(negedge sys_clk) if (rdSeen) chk(expQ.pop_front(), sfrRdData_reg);
// pulse outputs stand one cycle, so count them where they are settled
always @(negedge sys_clk) begin
    if (intRequest_reg === 1'b1) nIrq++;
    if (watchdogReset_reg === 1'b1) nWd++;
end
task automatic chk_cnt(input string nm, input int e, input int s);
    n_checks++;
    if (s !== e) begin err_total++; $display("BAD %s exp %0d got %0d", nm, e, s); end
endtask
task automatic close_out;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
        $display("STATUS OK");
    else
        $display("STATUS NOT OK");
    $finish;
endtask
initial begin
    void'($urandom(32'h3c6e0816));
    cyc(3); rstn = 1; cyc(1);
    rd(8'hd8, 8'h00);
    rd(8'hd9, 8'h00);
    // full wrap of the counter: 65536 ticks bring it back to zero
    wr(8'h40); counterTick = 1; cyc(65536); counterTick = 0; cyc(3);
    rd(8'hd8, 8'hc0);
    m = 6'($urandom) | 6'h01; moduleEvent = m; cyc(1); moduleEvent = 6'h00; cyc(3);
    rd(8'hd8, {2'b11, m});
    wr(8'h40); rd(8'hd8, 8'h40);
    // hardware set lands in the same cycle as a written zero
    moduleEvent = 6'h01; sfrWrEn = 1; sfrWrData = 8'h40; cyc(1); moduleEvent = 6'h00; sfrWrEn = 0; cyc(2);
    rd(8'hd8, 8'h41);
    watchdogEnable = 1; wr(8'h20); counterTick = 1; cyc(4); counterTick = 0;
    // run bit write of 0 is ignored under watchdog, software set of flag five sets it
    rd(8'hd8, 8'h60);
    chk_cnt("watchdogReset_reg", 1, nWd);
    // overflow, random module events, same-cycle set, software set of flag five
    chk_cnt("intRequest_reg", 4, nIrq);
    chk_cnt("counter_reg", 4, counter_reg);
    close_out;
end
endmodule // tb
